// ### core/bsl_pkg.sv
package bsl_pkg;
    // register byte offsets
    localparam logic [4:0] BSL_OFS_CTRL = 5'h00;
    localparam logic [4:0] BSL_OFS_DESC = 5'h04;
    localparam logic [4:0] BSL_OFS_STAT = 5'h08;
    localparam logic [4:0] BSL_OFS_LOC  = 5'h0C;
    localparam logic [4:0] BSL_OFS_BANK = 5'h10;
    // field positions
    localparam int BSL_CTRL_CONSOLE = 0;
    localparam int BSL_CTRL_LOADBTN = 1;
    localparam int BSL_STAT_LAMP    = 16;
    localparam int BSL_STAT_OCTAL   = 17;
    localparam int BSL_DESC_EXT     = 15;
    localparam int BSL_DESC_RESTART = 14;
    localparam int BSL_DESC_MASS    = 13;
    localparam int BSL_DESC_OCTAL   = 12;
    // reset values
    localparam logic        BSL_RST_CONSOLE = 1'b1;
    localparam logic [15:0] BSL_RST_ADDR    = 16'h0000;
    // characters
    localparam logic [7:0] BSL_CH_BANG  = 8'h21;
    localparam logic [7:0] BSL_CH_LF    = 8'h0A;
    localparam logic [7:0] BSL_CH_CR    = 8'h0D;
    localparam logic [7:0] BSL_CH_AT    = 8'h40;
    localparam logic [7:0] BSL_CH_DOLL  = 8'h24;
    localparam logic [7:0] BSL_CH_AMP   = 8'h26;
    localparam logic [7:0] BSL_CH_STAR  = 8'h2A;
    localparam logic [7:0] BSL_CH_SLASH = 8'h2F;
    localparam logic [7:0] BSL_CH_BANK  = 8'h42;
    localparam logic [7:0] BSL_CH_QUERY = 8'h3F;
    localparam logic [7:0] BSL_CH_ZERO  = 8'h30;
    localparam logic [7:0] BSL_CH_SEVEN = 8'h37;
    // counts
    localparam logic [10:0] BSL_MS_WORDS   = 11'h400;
    localparam logic [2:0]  BSL_PRT_DIGITS = 3'h6;
    // loader states, one-hot
    typedef enum logic [12:0] {
        BSL_IDLE  = 13'h0001,
        BSL_SKIP  = 13'h0002,
        BSL_ADR_H = 13'h0004,
        BSL_ADR_L = 13'h0008,
        BSL_CNT_H = 13'h0010,
        BSL_CNT_L = 13'h0020,
        BSL_DAT_H = 13'h0040,
        BSL_DAT_L = 13'h0080,
        BSL_SUM_H = 13'h0100,
        BSL_SUM_L = 13'h0200,
        BSL_ACT   = 13'h0400,
        BSL_MASS  = 13'h0800,
        BSL_PRINT = 13'h1000
    } bsl_state_t;
endpackage : bsl_pkg

// ### core/bsl_acc_if.sv
`timescale 1ns/1ps
// octal number accumulator link
interface bsl_acc_if;
    logic        clr;        // drop collected digits
    logic        shift;      // take one digit
    logic [2:0]  digit;      // digit value
    logic [15:0] value;      // number so far
    logic        has_digits; // at least one digit seen
    modport owner (output clr, shift, digit, input value, has_digits);
    modport acc   (input clr, shift, digit, output value, has_digits);
endinterface : bsl_acc_if

// ### core/bsl_octal_acc.sv
`timescale 1ns/1ps
module bsl_octal_acc
    import bsl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // digit link
    bsl_acc_if.acc   link
);
    typedef struct packed {
        logic [15:0] value;
        logic        seen;
    } bsl_acc_t;

    bsl_acc_t s_q, s_d;

    // clear wins over shift: a terminator ends the number
    always_comb begin
        s_d = s_q;
        if (link.clr) begin
            s_d.value = BSL_RST_ADDR;
            s_d.seen  = 1'b0;
        end else if (link.shift) begin
            // high digits fall off the top, as on a 16-bit word
            s_d.value = {s_q.value[12:0], link.digit};
            s_d.seen  = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.value      = s_q.value;
    assign link.has_digits = s_q.seen;
endmodule : bsl_octal_acc

// ### core/bsl_loader.sv
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module bsl_loader
    import bsl_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // panel
    input  wire logic [15:0] load_descriptor_switch,
    output logic             attention_lamp,
    // character input, from console or redirected device
    input  wire logic        char_valid,
    input  wire logic [7:0]  char_data,
    output logic             char_ready,
    output logic [10:0]      input_dev_addr,
    output logic             octal_load_active,
    // character output to console
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    // main memory write
    output logic             mem_wr,
    output logic [15:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    // mass storage word reads
    output logic             ms_req,
    output logic [10:0]      ms_dev,
    output logic [9:0]       ms_word_addr,
    input  wire logic        ms_ack,
    input  wire logic [15:0] ms_data,
    input  wire logic        ms_err,
    // processor control
    output logic             cpu_start,
    output logic [15:0]      cpu_start_addr,
    output logic             ujump,
    output logic [11:0]      ujump_addr,
    output logic [15:0]      level0_pc,
    output logic             priority_irq_enable_clr,
    output logic [1:0]       bank_sel,
    output logic [15:0]      loc_counter
);
    typedef struct packed {
        bsl_state_t  st;
        logic        console;   // console fitted
        logic        lamp;      // attention lamp
        logic        octal;     // input redirected for octal load
        logic [10:0] dev;       // selected input device
        logic [1:0]  bank;
        logic [15:0] loc;       // location counter
        logic [15:0] start_b;   // optional start address
        logic [15:0] blk;       // next store address
        logic [15:0] cnt;       // data words left
        logic [15:0] sum;       // running checksum
        logic [7:0]  hi;        // held high byte
        logic [10:0] ms_n;      // mass words done
        logic [2:0]  prt_n;     // octal digits left
        logic [17:0] prt_v;
        logic        tx_v;
        logic [7:0]  tx_d;
        logic        run_v;
        logic [15:0] run_a;
        logic        uj_v;
        logic [11:0] uj_a;
        logic [15:0] pc0;
        logic        pie_clr;
        logic        mem_wr;
        logic [15:0] mem_a;
        logic [15:0] mem_d;
        logic        ms_req;
        logic        rdy;
        logic        wait_n;    // inverted waitrequest
        logic [31:0] rdata;
    } bsl_state_s_t;

    bsl_state_s_t s_q, s_d;
    bsl_acc_if    acc ();       // number being typed

    bsl_octal_acc u_acc (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .link    (acc.acc)
    );

    // handshakes and decodes
    logic       take;           // character accepted this cycle
    logic       is_oct;         // character is an octal digit
    logic       bus_req;        // bus request taken this cycle, answered the next
    logic       btn;            // load button pressed via register
    logic [7:0] ch;
    assign take    = char_valid && s_q.rdy;
    assign ch      = char_data;
    assign is_oct  = (ch >= BSL_CH_ZERO) && (ch <= BSL_CH_SEVEN);
    assign bus_req = (avs_read || avs_write) && !s_q.wait_n;
    assign btn     = bus_req && avs_write && (avs_address == BSL_OFS_CTRL)
                     && avs_writedata[BSL_CTRL_LOADBTN];

    // next state of everything
    always_comb begin
        logic        cmd;       // character goes to command decode
        logic        fail;      // flag an error
        logic        desc_go;   // run a descriptor load
        logic        force_oct;
        logic [15:0] w;
        s_d       = s_q;
        cmd       = 1'b0;
        fail      = 1'b0;
        desc_go   = 1'b0;
        force_oct = 1'b0;
        w         = {s_q.hi, ch};
        acc.clr   = 1'b0;
        acc.shift = 1'b0;
        acc.digit = ch[2:0];
        // pulses last one cycle
        s_d.tx_v    = 1'b0;
        s_d.run_v   = 1'b0;
        s_d.uj_v    = 1'b0;
        s_d.pie_clr = 1'b0;
        s_d.mem_wr  = 1'b0;
        s_d.wait_n  = 1'b0;

        // register bus, one wait cycle per access
        if ((avs_read || avs_write) && !s_q.wait_n) begin
            s_d.wait_n = 1'b1;
            s_d.rdata  = '0;
            if (avs_read) begin
                case (avs_address)
                    BSL_OFS_CTRL: s_d.rdata[BSL_CTRL_CONSOLE] = s_q.console;
                    BSL_OFS_DESC: s_d.rdata[15:0] = load_descriptor_switch;
                    BSL_OFS_STAT: begin
                        s_d.rdata[12:0]           = s_q.st;
                        s_d.rdata[BSL_STAT_LAMP]  = s_q.lamp;
                        s_d.rdata[BSL_STAT_OCTAL] = s_q.octal;
                    end
                    BSL_OFS_LOC:  s_d.rdata[15:0] = s_q.loc;
                    BSL_OFS_BANK: s_d.rdata[1:0]  = s_q.bank;
                    default:      s_d.rdata = '0;
                endcase
            end else if (avs_address == BSL_OFS_CTRL) begin
                s_d.console = avs_writedata[BSL_CTRL_CONSOLE];
            end else if (avs_address == BSL_OFS_STAT && avs_writedata[BSL_STAT_LAMP]) begin
                s_d.lamp = 1'b0;            // write one to clear
            end
        end

        // loader sequence
        case (s_q.st)
            BSL_IDLE: begin
                if (take) begin
                    cmd = 1'b1;
                end else if (btn) begin
                    desc_go = 1'b1;
                end
            end
            BSL_SKIP: if (take) begin
                if (ch == BSL_CH_BANG) begin
                    acc.clr = 1'b1;
                    s_d.st  = BSL_ADR_H;
                end else if (is_oct) begin
                    acc.shift = 1'b1;
                end else if (ch != BSL_CH_LF) begin
                    // line feed inside numbers is dropped
                    acc.clr = 1'b1;
                    if (acc.has_digits) begin
                        s_d.start_b = acc.value;
                    end
                end
            end
            BSL_ADR_H, BSL_CNT_H, BSL_DAT_H, BSL_SUM_H: if (take) begin
                s_d.hi = ch;
                s_d.st = bsl_state_t'(s_q.st << 1);
            end
            BSL_ADR_L: if (take) begin
                s_d.blk = w;
                s_d.st  = BSL_CNT_H;
            end
            BSL_CNT_L: if (take) begin
                s_d.cnt = w;
                s_d.sum = '0;
                s_d.st  = (w == 16'h0000) ? BSL_SUM_H : BSL_DAT_H;
            end
            BSL_DAT_L: if (take) begin
                s_d.mem_wr = 1'b1;
                s_d.mem_a  = s_q.blk;
                s_d.mem_d  = w;
                s_d.blk    = s_q.blk + 16'h0001;
                s_d.sum    = s_q.sum + w;
                s_d.cnt    = s_q.cnt - 16'h0001;
                s_d.st     = (s_q.cnt == 16'h0001) ? BSL_SUM_H : BSL_DAT_H;
            end
            BSL_SUM_L: if (take) begin
                if (w != s_q.sum) begin
                    fail   = 1'b1;
                    s_d.st = BSL_IDLE;
                end else begin
                    s_d.st = BSL_ACT;
                end
            end
            BSL_ACT: if (take) begin
                s_d.st = BSL_IDLE;
                if (ch == 8'h00) begin
                    s_d.run_v = 1'b1;
                    s_d.run_a = s_q.start_b;
                end else begin
                    s_d.pc0 = s_q.start_b;
                    cmd     = 1'b1;
                end
            end
            BSL_MASS: begin
                if (ms_err) begin
                    s_d.ms_req = 1'b0;
                    fail       = 1'b1;
                    s_d.st     = BSL_IDLE;
                end else if (ms_ack) begin
                    s_d.mem_wr = 1'b1;
                    s_d.mem_a  = {5'h00, s_q.ms_n};
                    s_d.mem_d  = ms_data;
                    s_d.ms_n   = s_q.ms_n + 11'h001;
                    if (s_q.ms_n == BSL_MS_WORDS - 11'h001) begin
                        s_d.ms_req = 1'b0;
                        s_d.run_v  = 1'b1;
                        s_d.run_a  = BSL_RST_ADDR;
                        s_d.st     = BSL_IDLE;
                    end
                end
            end
            BSL_PRINT: begin
                // one octal digit per cycle, top digit first
                s_d.tx_v  = 1'b1;
                s_d.tx_d  = BSL_CH_ZERO | {5'h00, s_q.prt_v[17:15]};
                s_d.prt_v = {s_q.prt_v[14:0], 3'h0};
                s_d.prt_n = s_q.prt_n - 3'h1;
                if (s_q.prt_n == 3'h1) begin
                    s_d.st = BSL_IDLE;
                end
            end
            default: s_d.st = BSL_IDLE;
        endcase

        // operator command decode
        if (cmd) begin
            if (!s_q.octal && s_q.st == BSL_IDLE) begin
                s_d.tx_v = 1'b1;            // echo only outside octal load
                s_d.tx_d = ch;
            end
            if (is_oct) begin
                acc.shift = 1'b1;
            end else if (ch == BSL_CH_LF) begin
                s_d.tx_v = s_q.octal ? 1'b0 : s_d.tx_v;
            end else begin
                acc.clr = 1'b1;
                case (ch)
                    BSL_CH_AT: begin
                        s_d.octal   = 1'b0;
                        s_d.pie_clr = 1'b1;
                    end
                    BSL_CH_STAR: begin
                        s_d.prt_v = {2'b00, s_q.loc};
                        s_d.prt_n = BSL_PRT_DIGITS;
                        s_d.st    = BSL_PRINT;
                    end
                    BSL_CH_SLASH: s_d.loc = acc.value;
                    BSL_CH_CR:    s_d.loc = s_q.loc + 16'h0001;
                    BSL_CH_BANK:  s_d.bank = acc.value[1:0];
                    BSL_CH_BANG: begin
                        s_d.octal = 1'b0;
                        s_d.run_v = 1'b1;
                        s_d.run_a = acc.value;
                    end
                    BSL_CH_DOLL: begin
                        if (acc.has_digits) begin
                            s_d.dev   = acc.value[10:0];
                            s_d.octal = 1'b1;
                        end else begin
                            desc_go   = 1'b1;
                            force_oct = 1'b1;
                        end
                    end
                    BSL_CH_AMP: begin
                        if (acc.has_digits) begin
                            s_d.dev     = acc.value[10:0];
                            s_d.octal   = 1'b0;
                            s_d.start_b = BSL_RST_ADDR;
                            s_d.st      = BSL_SKIP;
                        end else begin
                            desc_go = 1'b1;
                        end
                    end
                    default: begin
                        fail      = 1'b1;
                        s_d.octal = 1'b0;
                    end
                endcase
            end
        end

        // descriptor dispatch, highest bit wins
        if (desc_go) begin
            s_d.dev = load_descriptor_switch[10:0];
            if (load_descriptor_switch[BSL_DESC_EXT]) begin
                s_d.uj_v  = 1'b1;
                s_d.uj_a  = load_descriptor_switch[11:0];
                s_d.octal = 1'b0;
            end else if (load_descriptor_switch[BSL_DESC_RESTART]) begin
                s_d.run_v = 1'b1;
                s_d.run_a = {load_descriptor_switch[13:0], 2'b00};
                s_d.octal = 1'b0;
            end else if (load_descriptor_switch[BSL_DESC_MASS]) begin
                s_d.ms_req = 1'b1;
                s_d.ms_n   = '0;
                s_d.octal  = 1'b0;
                s_d.st     = BSL_MASS;
            end else if (force_oct || load_descriptor_switch[BSL_DESC_OCTAL]) begin
                s_d.octal = 1'b1;
            end else begin
                s_d.octal   = 1'b0;
                s_d.start_b = BSL_RST_ADDR;
                s_d.st      = BSL_SKIP;
            end
        end

        // error shows on console, or on the lamp without one
        if (fail) begin
            if (s_q.console) begin
                s_d.tx_v = 1'b1;
                s_d.tx_d = BSL_CH_QUERY;
            end else begin
                s_d.lamp = 1'b1;
            end
        end
        // stall input while printing and in mass load
        s_d.rdy = (s_d.st != BSL_PRINT) && (s_d.st != BSL_MASS);
    end

    // state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q         <= '0;
            s_q.st      <= BSL_IDLE;
            s_q.console <= BSL_RST_CONSOLE;
            s_q.rdy     <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign avs_readdata            = s_q.rdata;
    assign avs_waitrequest         = !s_q.wait_n;
    assign attention_lamp          = s_q.lamp;
    assign char_ready              = s_q.rdy;
    assign input_dev_addr          = s_q.dev;
    assign octal_load_active       = s_q.octal;
    assign tx_valid                = s_q.tx_v;
    assign tx_data                 = s_q.tx_d;
    assign mem_wr                  = s_q.mem_wr;
    assign mem_addr                = s_q.mem_a;
    assign mem_wdata               = s_q.mem_d;
    assign ms_req                  = s_q.ms_req;
    assign ms_dev                  = s_q.dev;
    assign ms_word_addr            = s_q.ms_n[9:0];
    assign cpu_start               = s_q.run_v;
    assign cpu_start_addr          = s_q.run_a;
    assign ujump                   = s_q.uj_v;
    assign ujump_addr              = s_q.uj_a;
    assign level0_pc               = s_q.pc0;
    assign priority_irq_enable_clr = s_q.pie_clr;
    assign bank_sel                = s_q.bank;
    assign loc_counter             = s_q.loc;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_cmd(logic [7:0] c);
        take && s_q.st == BSL_IDLE && ch == c;
    endsequence
    sequence s_data_low;
        take && s_q.st == BSL_DAT_L;
    endsequence

    a_break_clear: assert property (s_cmd(BSL_CH_AT) |=> priority_irq_enable_clr && !octal_load_active)
        else $error("break did not clear enables");
    a_bank_pick: assert property (s_cmd(BSL_CH_BANK) |=> bank_sel == $past(acc.value[1:0]))
        else $error("bank not taken from number");
    a_loc_step: assert property (s_cmd(BSL_CH_CR) |=> loc_counter == $past(loc_counter) + 16'h0001)
        else $error("location counter did not step");
    a_quiet_octal: assert property (take && s_q.octal && s_q.st == BSL_IDLE && is_oct |=> !tx_valid)
        else $error("echo during octal load");
    a_word_store: assert property (s_data_low |=> mem_wr && mem_wdata == {$past(s_q.hi), $past(ch)})
        else $error("data word not stored");
    a_sum_flag: assert property (take && s_q.st == BSL_SUM_L && {s_q.hi, ch} != s_q.sum
                                 |=> (tx_valid && tx_data == BSL_CH_QUERY) || attention_lamp)
        else $error("checksum error not flagged");
    a_ext_first: assert property (btn && s_q.st == BSL_IDLE && load_descriptor_switch[BSL_DESC_EXT]
                                  |=> ujump && !cpu_start && !ms_req)
        else $error("extension bit lost priority");
    a_restart_addr: assert property (btn && s_q.st == BSL_IDLE && load_descriptor_switch[15:14] == 2'b01
                                     |=> cpu_start && cpu_start_addr[1:0] == 2'b00)
        else $error("restart address wrong");
    a_mass_done: assert property (s_q.st == BSL_MASS && ms_ack && !ms_err && s_q.ms_n == 11'h3FF
                                  |=> cpu_start && cpu_start_addr == 16'h0000 ##1 char_ready)
        else $error("mass load did not start at zero");
endmodule : bsl_loader

// ### tb/bsl_src_model.sv
`timescale 1ns/1ps
// far side: byte source feeding char port, plus a slow mass storage unit
module bsl_src_model (
    // clock
    input  wire logic        clk_sys,
    // character source
    input  wire logic        char_ready,
    output logic             char_valid,
    output logic [7:0]       char_data,
    // mass storage
    input  wire logic        ms_req,
    input  wire logic [9:0]  ms_word_addr,
    output logic             ms_ack,
    output logic [15:0]      ms_data,
    output logic             ms_err
);
    logic [7:0] q[$]; // bytes not yet taken
    logic       ms_fail; // answer with an error instead of data
    initial begin
        {char_valid, ms_ack, ms_err} = 3'h0;
        ms_fail = 1'b0;
        char_data = 8'h00;
        ms_data = 16'h0000;
    end
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask : push
    // byte held until taken; an idle line shows the inverse, never stale data
    always @(posedge clk_sys) begin
        if (char_valid && char_ready) void'(q.pop_front());
        char_valid <= (q.size() != 0);
        char_data <= (q.size() != 0) ? q[0] : ~char_data;
        // answer every other cycle; data is the word index itself; a failing unit flags an error instead
        ms_ack <= ms_req && !ms_ack && !ms_fail;
        ms_err <= ms_req && !ms_ack && ms_fail;
        ms_data <= (ms_req && !ms_ack) ? {6'h00, ms_word_addr} : ~ms_data;
    end
endmodule : bsl_src_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb
    import bsl_pkg::*;
;
    logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest, attention_lamp, char_valid, char_ready;
    logic octal_load_active, tx_valid, mem_wr, ms_req, ms_ack, ms_err, cpu_start, ujump, priority_irq_enable_clr;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, r, txl;
    logic [15:0] load_descriptor_switch, mem_addr, mem_wdata, ms_data, cpu_start_addr, level0_pc, loc_counter, wa, wd, sa;
    logic [10:0] input_dev_addr, ms_dev;
    logic [9:0] ms_word_addr;
    logic [7:0] char_data, tx_data;
    logic [11:0] ujump_addr, ua;
    logic [1:0] bank_sel;
    logic st, uj, priority_irq_enable_reg;
    int n_fail, total_checks, n_wr, n_tx;
    // good block at 0x1000, two words, then zero action; then a bad-sum block; then an empty block ending in a command
    logic [7:0] blk[26] = '{8'h10, 8'h00, 8'h00, 8'h02, 8'h12, 8'h34, 8'h00, 8'h01, 8'h12, 8'h35, 8'h00,
                           8'h00, 8'h20, 8'h00, 8'h01, 8'h00, 8'h05, 8'h00, 8'h06,
                           8'h00, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
    bsl_loader bsl_loader_inst (.*);
    bsl_src_model bsl_src_model_inst (.*);
    initial begin
        clk_sys = 0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // capture one-cycle pulses at the edge where they stand
    always @(posedge clk_sys) begin
        if (mem_wr === 1'b1) {n_wr, wa, wd} = {n_wr + 1, mem_addr, mem_wdata};
        if (cpu_start === 1'b1) {st, sa} = {1'b1, cpu_start_addr};
        if (ujump === 1'b1) {uj, ua} = {1'b1, ujump_addr};
        if (tx_valid === 1'b1) {n_tx, txl} = {n_tx + 1, txl[23:0], tx_data};
        if (priority_irq_enable_clr === 1'b1) priority_irq_enable_reg = 1'b1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one avalon access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        {avs_read, avs_write} <= 2'h0;
        @(posedge clk_sys);
    endtask : acc
    task automatic send(input string s);
        foreach (s[i]) bsl_src_model_inst.push(s[i]);
    endtask : send
    task automatic drain;
        while (bsl_src_model_inst.q.size() != 0) @(posedge clk_sys);
        repeat (10) @(posedge clk_sys);
    endtask : drain
    task automatic load(input logic [15:0] desc);
        {st, uj, n_wr} = 0;
        load_descriptor_switch <= desc;
        acc(1'b1, BSL_OFS_CTRL, 32'h00000002);
        while (!st && !uj) @(posedge clk_sys);
    endtask : load
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    initial begin
        {reset_n, avs_read, avs_write, st, uj, priority_irq_enable_reg, n_wr, n_tx, n_fail, total_checks, txl} = 0;
        {avs_address, avs_writedata} = 0;
        load_descriptor_switch = 16'h00C0;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1;
        acc(1'b0, BSL_OFS_CTRL, 0);
        chk(r, 32'h00000001);
        acc(1'b0, 5'h14, 0);
        chk(r, 32'h00000000);
        acc(1'b0, BSL_OFS_DESC, 0);
        chk(r, 32'h000000C0);
        send("17/\0156B");
        drain;
        chk(loc_counter, 32'h00000010);
        chk(bank_sel, 32'h00000002);
        send("5$12*");
        drain;
        chk(input_dev_addr, 32'h00000005);
        chk(octal_load_active, 32'h00000001);
        chk(n_tx, 32'h0000000E);
        chk(txl, 32'h30303230);
        send("@");
        drain;
        chk({octal_load_active, priority_irq_enable_reg}, 32'h00000001);
        send("7$X");
        drain;
        chk(txl, 32'h3037243F);
        chk(octal_load_active, 32'h00000000);
        send("300&1\n7 !");
        for (int i = 0; i < 11; i++) bsl_src_model_inst.push(blk[i]);
        while (!st) @(posedge clk_sys);
        chk(input_dev_addr, 32'h000000C0);
        chk(n_wr, 32'h00000002);
        chk({wa, wd}, {16'h1001, 16'h0001});
        chk(sa, 32'h0000000F);
        acc(1'b1, BSL_OFS_CTRL, 0);
        send("300&!");
        for (int i = 11; i < 19; i++) bsl_src_model_inst.push(blk[i]);
        while (attention_lamp !== 1'b1) @(posedge clk_sys);
        acc(1'b1, BSL_OFS_STAT, 32'h00010000);
        chk(attention_lamp, 32'h0);
        {st, priority_irq_enable_reg} = 2'b00;
        send("300&5 !");
        for (int i = 19; i < 26; i++) bsl_src_model_inst.push(blk[i]);
        drain;
        chk(level0_pc, 32'h00000005);
        chk({st, priority_irq_enable_reg}, 32'h00000001);
        bsl_src_model_inst.ms_fail = 1'b1;
        load_descriptor_switch <= 16'h2160;
        acc(1'b1, BSL_OFS_CTRL, 32'h00000002);
        while (attention_lamp !== 1'b1) @(posedge clk_sys);
        chk({ms_req, ms_dev}, 32'h00000160);
        bsl_src_model_inst.ms_fail = 1'b0;
        load(16'h2160);
        chk(n_wr, 32'h00000400);
        chk({wa, wd}, 32'h03FF03FF);
        chk(sa, 32'h00000000);
        load(16'h7FF0);
        chk(sa, 32'h0000FFC0);
        load(16'hFFFF);
        chk({uj, ua}, 32'h00001FFF);
        load_descriptor_switch <= 16'h0123;
        send("$");
        drain;
        chk({octal_load_active, input_dev_addr}, 32'h00000923);
        close_out;
    end
    initial begin
        #200000;
        n_fail++;
        close_out;
    end
endmodule : tb
